// ### wwd_pkg.sv
package wwd_pkg;
   // -------------------------------------------------------------------
   // service register layout
   // -------------------------------------------------------------------
   localparam int          WIN_MSB       = 7;
   localparam int          WIN_LSB       = 6;
   localparam int          KEY_MSB       = 5;
   localparam int          KEY_LSB       = 1;
   localparam int          CLKMON_BIT    = 0;
   localparam logic [4:0]  SVC_KEY       = 5'h0c;
   localparam logic [1:0]  WIN_RST       = 2'h3;
   localparam logic        CLKMON_RST    = 1'b1;
   localparam int          OPT_WD_BIT    = 2;

   // -------------------------------------------------------------------
   // timing: window limits in idle timer clocks, hold and monitor in MCLK cycles
   // -------------------------------------------------------------------
   localparam int          WIN_W         = 17;
   localparam logic [16:0] LOWER_LIMIT   = 17'h00800;
   localparam logic [16:0] UPPER_8K      = 17'h02000;
   localparam int          HOLD_MIN      = 16;
   localparam int          HOLD_W        = 6;
   // clock monitor: reject when tick gap exceeds 5 kHz period at 200 MHz
   localparam int          CLK_HZ        = 200_000_000;
   localparam int          MON_MIN_HZ    = 5_000;
   localparam int          MON_LIMIT_CYC = CLK_HZ / MON_MIN_HZ;
   localparam int          MON_W         = 16;
   localparam int          TAP_W         = 3;
   localparam int          IDLE_W        = 16;

   typedef struct packed {
      logic [1:0] win;
      logic [4:0] key;
      logic       clkmon;
   } wwd_svc_t;

   typedef enum logic [1:0] {
      WWD_IDLE  = 2'b00,
      WWD_DRIVE = 2'b01,
      WWD_HOLD  = 2'b11
   } wwd_pin_st_t;
endpackage

// ### wwd_sync.sv
`timescale 1ns/10ps
`default_nettype none
module wwd_sync
(
   // clock and reset
   input  wire logic MCLK_I,
   input  wire logic RST_N_I,
   // pin level in, filtered level out
   input  wire logic async_i,
   output logic      level_o
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;

   // change counts once stages two and three agree
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         s1_ff   <= 1'b1;
         s2_ff   <= 1'b1;
         s3_ff   <= 1'b1;
         level_o <= 1'b1;
      end
      else
      begin
         s1_ff <= async_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff)
            level_o <= s3_ff;
      end
   end
endmodule
`default_nettype wire

// ### wwd_idle_timer.sv
`timescale 1ns/10ps
`default_nettype none
module wwd_idle_timer
   import wwd_pkg::*;
(
   // clock and reset
   input  wire logic             MCLK_I,
   input  wire logic             RST_N_I,
   // count and tap
   input  wire logic             tick_i,
   input  wire logic [TAP_W-1:0] tap_sel_i,
   input  wire logic             pend_clr_i,
   output logic                  pend_o,
   output logic [IDLE_W-1:0]     count_o
);
   logic [IDLE_W-1:0] cnt_ff = '0;
   logic              pend_ff;
   logic [IDLE_W-1:0] nxt_cnt;
   wire  [3:0]        tap_idx = 4'(4'd11 + {1'b0, tap_sel_i});
   wire               toggled;

   assign nxt_cnt = cnt_ff + IDLE_W'(1);
   assign toggled = tick_i && (nxt_cnt[tap_idx] != cnt_ff[tap_idx]);
   assign pend_o  = pend_ff;
   assign count_o = cnt_ff;

   always_ff @(posedge MCLK_I)
      if (tick_i)
         cnt_ff <= nxt_cnt;

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         pend_ff <= 1'b0;
      else if (toggled)
         pend_ff <= 1'b1;
      else if (pend_clr_i)
         pend_ff <= 1'b0;
   end
endmodule
`default_nettype wire

// ### wwd_top.sv
`timescale 1ns/10ps
`default_nettype none
module wwd_top
   import wwd_pkg::*;
(
   // clock and reset
   input  wire logic             MCLK_I,
   input  wire logic             RST_N_I,
   // option and timing inputs
   input  wire logic [7:0]       OPTION_I,
   input  wire logic             IDLE_TICK_I,
   input  wire logic             INSTR_CLK_I,
   // power and boot rom state
   input  wire logic             HALT_I,
   input  wire logic             IDLE_I,
   input  wire logic             BOOT_ENTER_I,
   input  wire logic             BOOT_EXIT_I,
   // service register access
   input  wire logic             SVC_WR_I,
   input  wire logic [7:0]       SVC_WDATA_I,
   output logic      [7:0]       SVC_RDATA_O,
   // idle timer
   input  wire logic [TAP_W-1:0] TAP_SEL_I,
   input  wire logic             PEND_CLR_I,
   output logic                  IDLE_PEND_O,
   // error pin, open drain
   input  wire logic             ERR_PIN_I,
   output logic                  ERR_PIN_O,
   output logic                  ERR_PIN_OE_O
);
   import wwd_pkg::*;

   wwd_svc_t          svc_ff;
   logic              first_ff;
   logic              lower_en_ff;
   logic [WIN_W-1:0]  win_cnt_ff;
   logic              halt_d_ff;
   logic              idle_d_ff;
   wwd_pin_st_t       st_ff;
   logic [HOLD_W-1:0] hold_ff;
   logic [MON_W-1:0]  mon_cnt_ff;
   logic              ic_d_ff;
   logic              pin_lvl;
   logic              ic_lvl;

   wire wd_en = ~OPTION_I[OPT_WD_BIT];
   wire wd_run = wd_en && !HALT_I && !IDLE_I;
   wwd_svc_t wr;
   assign wr = wwd_svc_t'(SVC_WDATA_I);

   function automatic logic [WIN_W-1:0] upper_of(input logic [1:0] w);
      upper_of = UPPER_8K << w;
   endfunction

   // -------------------------------------------------------------------
   // pin synchronisers and idle timer
   // -------------------------------------------------------------------
   wwd_sync u_pin_sync
   (
      .MCLK_I  (MCLK_I),
      .RST_N_I (RST_N_I),
      .async_i (ERR_PIN_I),
      .level_o (pin_lvl)
   );

   wwd_sync u_ic_sync
   (
      .MCLK_I  (MCLK_I),
      .RST_N_I (RST_N_I),
      .async_i (INSTR_CLK_I),
      .level_o (ic_lvl)
   );

   wwd_idle_timer u_idle
   (
      .MCLK_I     (MCLK_I),
      .RST_N_I    (RST_N_I),
      .tick_i     (IDLE_TICK_I),
      .tap_sel_i  (TAP_SEL_I),
      .pend_clr_i (PEND_CLR_I),
      .pend_o     (IDLE_PEND_O),
      .count_o    ()
   );

   // -------------------------------------------------------------------
   // clock monitor
   // -------------------------------------------------------------------
   wire ic_edge = ic_lvl != ic_d_ff;
   // gap past 5 kHz period rejects; 10 Hz always far beyond it
   wire mon_err = svc_ff.clkmon && (mon_cnt_ff >= MON_W'(MON_LIMIT_CYC));

   // monitor counts regardless of halt or idle
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         // matches the synchroniser's reset level, so no false edge
         ic_d_ff    <= 1'b1;
         mon_cnt_ff <= '0;
      end
      else
      begin
         ic_d_ff <= ic_lvl;
         if (ic_edge)
            mon_cnt_ff <= '0;
         else if (mon_cnt_ff != MON_W'(MON_LIMIT_CYC))
            mon_cnt_ff <= mon_cnt_ff + MON_W'(1);
      end
   end

   // -------------------------------------------------------------------
   // service decode
   // -------------------------------------------------------------------
   wire driving = (st_ff != WWD_IDLE);
   wire svc_take = SVC_WR_I && wd_en && !driving;
   wire key_ok = (wr.key == SVC_KEY);
   wire all_ok = key_ok && (wr.win == svc_ff.win)
                 && (wr.clkmon == svc_ff.clkmon);
   wire wr_ok = first_ff ? key_ok : all_ok;
   // early service error when lower check active
   wire early = lower_en_ff && !first_ff && (win_cnt_ff < LOWER_LIMIT);
   wire svc_err = svc_take && (!wr_ok || early);
   wire svc_good = svc_take && wr_ok && !early;
   wire late = wd_run && !driving && (win_cnt_ff >= upper_of(svc_ff.win));
   wire halt_exit = halt_d_ff && !HALT_I;
   wire idle_exit = idle_d_ff && !IDLE_I;
   wire hw_svc = BOOT_ENTER_I || BOOT_EXIT_I || idle_exit;
   wire wd_trig = svc_err || late;
   wire pin_release = (st_ff == WWD_HOLD) && (hold_ff == '0) && !mon_err;

   // -------------------------------------------------------------------
   // service register and window counter
   // -------------------------------------------------------------------
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         svc_ff      <= '{win: WIN_RST, key: SVC_KEY, clkmon: CLKMON_RST};
         first_ff    <= 1'b1;
         lower_en_ff <= 1'b0;
         win_cnt_ff  <= '0;
         halt_d_ff   <= 1'b0;
         idle_d_ff   <= 1'b0;
      end
      else
      begin
         halt_d_ff <= HALT_I;
         idle_d_ff <= IDLE_I;
         if (svc_take && first_ff && key_ok)
         begin
            svc_ff.win    <= wr.win;
            svc_ff.clkmon <= wr.clkmon;
         end
         if (svc_take)
            first_ff <= 1'b0;
         if (BOOT_ENTER_I)
            lower_en_ff <= 1'b0;
         // lower check armed by a good service write or by boot rom exit; boot rom entry in the same cycle wins
         else if (BOOT_EXIT_I || svc_good)
            lower_en_ff <= 1'b1;
         if (svc_good || hw_svc || halt_exit || pin_release || driving)
            win_cnt_ff <= '0;
         // count idle ticks only when running
         else if (wd_run && IDLE_TICK_I && !late)
            win_cnt_ff <= win_cnt_ff + WIN_W'(1);
      end
   end

   // -------------------------------------------------------------------
   // error pin sequencer
   // -------------------------------------------------------------------
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         st_ff   <= WWD_IDLE;
         hold_ff <= '0;
      end
      else
      begin
         unique case (st_ff)
            WWD_IDLE:
               if ((wd_en && wd_trig) || mon_err)
                  st_ff <= WWD_DRIVE;
            WWD_DRIVE:
               if (!pin_lvl)
               begin
                  st_ff   <= WWD_HOLD;
                  hold_ff <= HOLD_W'(HOLD_MIN);
               end
            WWD_HOLD:
               if (hold_ff != '0)
                  hold_ff <= hold_ff - HOLD_W'(1);
               else if (!mon_err)
                  st_ff <= WWD_IDLE;
         endcase
      end
   end

   // open drain low only when driving
   assign ERR_PIN_O    = 1'b0;
   assign ERR_PIN_OE_O = driving && (wd_en || mon_err);
   assign SVC_RDATA_O  = {svc_ff.win, 5'h00, svc_ff.clkmon};

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_N_I);

   key_read_zero_a: assert property (SVC_RDATA_O[5:1] == 5'h00)
      else $error("key field not zero on read");
   bad_key_err_a: assert property
      (svc_take && !key_ok |=> st_ff == WWD_DRIVE)
      else $error("bad key did not raise error");
   ignore_drive_a: assert property
      (SVC_WR_I && driving |=> $stable(svc_ff))
      else $error("write during active pin changed state");
   early_err_a: assert property
      (svc_take && key_ok && early |=> st_ff == WWD_DRIVE)
      else $error("early service not flagged");
   good_restart_a: assert property
      (svc_good |=> win_cnt_ff == '0)
      else $error("valid service did not restart window");
   halt_inhibit_a: assert property
      (HALT_I && !BOOT_EXIT_I && !BOOT_ENTER_I |=> $stable(win_cnt_ff)
       || win_cnt_ff == '0)
      else $error("window counted during halt");
   hold_min_a: assert property
      (st_ff == WWD_DRIVE ##1 st_ff == WWD_HOLD |-> st_ff == WWD_HOLD [*8])
      else $error("pin released too early");
   first_latch_a: assert property
      (!first_ff |=> $stable(svc_ff))
      else $error("service register changed after first write");
endmodule
`default_nettype wire

// ### wwd_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module wwd_top_bench;
   import wwd_pkg::*;

   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic             mclk;
   logic             rst_n;
   logic [7:0]       option;
   logic             idle_tick;
   logic             instr_clk;
   logic             halt;
   logic             idle;
   logic             boot_enter;
   logic             boot_exit;
   logic             svc_wr;
   logic [7:0]       svc_wdata;
   logic [7:0]       svc_rdata;
   logic [TAP_W-1:0] tap_sel;
   logic             pend_clr;
   logic             idle_pend;
   logic             err_pin;
   logic             err_oe;
   logic             tick_en;
   logic             ic_en;
   logic [5:0]       ic_div;
   int               fails;
   int               checked;
   int               n;

   // open drain pin, weak pull-up when nobody pulls low
   assign err_pin = ~err_oe;

   wwd_top dut_u
   (
      .MCLK_I       (mclk),
      .RST_N_I      (rst_n),
      .OPTION_I     (option),
      .IDLE_TICK_I  (idle_tick),
      .INSTR_CLK_I  (instr_clk),
      .HALT_I       (halt),
      .IDLE_I       (idle),
      .BOOT_ENTER_I (boot_enter),
      .BOOT_EXIT_I  (boot_exit),
      .SVC_WR_I     (svc_wr),
      .SVC_WDATA_I  (svc_wdata),
      .SVC_RDATA_O  (svc_rdata),
      .TAP_SEL_I    (tap_sel),
      .PEND_CLR_I   (pend_clr),
      .IDLE_PEND_O  (idle_pend),
      .ERR_PIN_I    (err_pin),
      .ERR_PIN_O    (),
      .ERR_PIN_OE_O (err_oe)
   );

   always #2.5 mclk = ~mclk;

   // idle tick every second cycle; instruction clock far above 5 kHz
   always @(negedge mclk)
   begin
      ic_div <= ic_div + 6'h01;
      idle_tick <= tick_en & ~idle_tick;
      if (ic_en && ic_div == 6'h00)
      begin
         instr_clk <= ~instr_clk;
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic ticks(input int k);
      repeat (2 * k) @(negedge mclk);
   endtask

   task automatic wr(input logic [7:0] d);
      @(negedge mclk);
      svc_wr = 1'b1;
      svc_wdata = d;
      @(negedge mclk);
      svc_wr = 1'b0;
   endtask

   task automatic pulse(ref logic s);
      @(negedge mclk);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
   endtask

   task automatic wait_oe(input logic v, input int lim, output int k);
      k = 0;
      while (err_oe !== v && k < lim)
      begin
         @(negedge mclk);
         k++;
      end
      if (k >= lim)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, err_oe, v);
         results();
      end
   endtask

   // looks for an error after a write; on error checks the hold length
   task automatic err_chk(input logic e);
      logic hit;
      int   hi;
      int   k;
      hit = 1'b0;
      hi = 0;
      repeat (4)
      begin
         @(negedge mclk);
         if (err_oe === 1'b1)
         begin
            hit = 1'b1;
            hi++;
         end
      end
      chk({7'h00, hit}, {7'h00, e});
      if (hit)
      begin
         wr(8'h00);
         wait_oe(1'b0, 100, k);
         chk({7'h00, (hi + 2 + k) >= 16 && (hi + 2 + k) <= 40}, 8'h01);
         chk(svc_rdata, 8'h01);
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      mclk = 1'b0; rst_n = 1'b0; option = 8'h04; idle_tick = 1'b0;
      instr_clk = 1'b0; halt = 1'b0; idle = 1'b0; boot_enter = 1'b0;
      boot_exit = 1'b0; svc_wr = 1'b0; svc_wdata = 8'h00;
      tap_sel = 3'h0; pend_clr = 1'b0; tick_en = 1'b1; ic_en = 1'b1;
      ic_div = 6'h00; fails = 0; checked = 0;
      repeat (8) @(negedge mclk);
      chk({7'h00, err_oe}, 8'h00);
      chk(svc_rdata, 8'hc1);
      rst_n = 1'b1;
      wr(8'hff);
      err_chk(1'b0);
      option = 8'h00;
      wr(8'h19);
      err_chk(1'b0);
      chk(svc_rdata, 8'h01);
      $display("reset and first service done");
      wr(8'h19);
      err_chk(1'b1);
      // window, key and monitor mismatches in turn
      ticks(2100);
      wr(8'h59);
      err_chk(1'b1);
      ticks(2100);
      wr(8'h1b);
      err_chk(1'b1);
      ticks(2100);
      wr(8'h18);
      err_chk(1'b1);
      pulse(pend_clr);
      chk({7'h00, idle_pend}, 8'h00);
      ticks(2100);
      chk({7'h00, idle_pend}, 8'h01);
      wr(8'h19);
      err_chk(1'b0);
      $display("service compare done");
      ticks(8100);
      chk({7'h00, err_oe}, 8'h00);
      wait_oe(1'b1, 400, n);
      wait_oe(1'b0, 100, n);
      $display("upper limit done");
      pulse(boot_enter);
      wr(8'h19);
      err_chk(1'b0);
      pulse(boot_exit);
      wr(8'h19);
      err_chk(1'b1);
      $display("boot rom done");
      // leaving either low-power mode restarts the lower limit
      halt = 1'b1;
      ticks(100);
      halt = 1'b0;
      wr(8'h19);
      err_chk(1'b1);
      idle = 1'b1;
      ticks(100);
      idle = 1'b0;
      wr(8'h19);
      err_chk(1'b1);
      $display("low power exit done");
      rst_n = 1'b0;
      repeat (8) @(negedge mclk);
      chk(svc_rdata, 8'hc1);
      rst_n = 1'b1;
      // stopped clock in halt: monitor still fires, ticks off
      tick_en = 1'b0;
      ic_en = 1'b0;
      halt = 1'b1;
      wait_oe(1'b1, 45000, n);
      chk({7'h00, n > 1000}, 8'h01);
      ic_en = 1'b1;
      halt = 1'b0;
      wait_oe(1'b0, 2000, n);
      $display("clock monitor done");
      results();
   end
endmodule
`default_nettype wire
